// [rtl/psp_regs.vh]
// Constants for the PHY strap-latch and shared-pin block: offsets, fields, resets.
// Assumes a 32-bit AXI4-Lite bus, one register per aligned word.
// Function
// - Five address straps, then pins output; the address-bit-three pin stays input-only here.
// - Address bit four always latches one.
// - Address-two pin is interrupt, polarity programmable.
// - Interrupt on selectable link events.
// - Reset restarts device and strap sampling.
// - Live rate pin: high 100M, low 10M.
// - Latch speed control source strap.
// - Latch full register access strap.
// - Latch crossover enable strap.
// - Receive isolate strap from receive-bit-one pin.
// - Duplex strap from receive-bit-zero pin.
// - Interface mode strap; pin then carrier/valid.
// - Role strap; pin then receive error.
// - Latch auto-negotiation enable strap.
// - Latch 10/100 speed strap.
// - Indicator 0 configurable, default activity.
// - Indicator 1 configurable, default speed.
// - Duplex/speed straps apply without negotiation.
// - Negotiation strap high enables; role low node.
// - Two receive bits per valid clock.
// - Two transmit bits per enable clock.
`ifndef PSP_REGS_VH
`define PSP_REGS_VH

// Register byte offsets
`define PSP_OFF_CTRL 8'h00
`define PSP_OFF_IRQ_EN 8'h04
`define PSP_OFF_IRQ_STAT 8'h08
`define PSP_OFF_LED_SEL 8'h0C
`define PSP_OFF_STRAPS 8'h10
`define PSP_OFF_LIVE 8'h14

// Control register fields
`define PSP_CTRL_IRQ_POL 0
`define PSP_CTRL_SPEED 1
`define PSP_CTRL_DUPLEX 2
`define PSP_CTRL_SPD_SRC 3

// Straps register fields
`define PSP_ST_ADDR_LSB 0
`define PSP_ST_AN 5
`define PSP_ST_DUPLEX 6
`define PSP_ST_SPEED 7
`define PSP_ST_SPD_SRC 8
`define PSP_ST_REGACC 9
`define PSP_ST_XOVER 10
`define PSP_ST_ISO 11
`define PSP_ST_RMII 12
`define PSP_ST_ROLE 13

// Reset values
`define PSP_IRQ_EN_RST 8'h00
`define PSP_LED_SEL_RST 10'h3A4
`define PSP_IRQ_POL_RST 1'b0

// Indicator function codes
`define PSP_LED_ACT 2'h0
`define PSP_LED_SPEED 2'h1
`define PSP_LED_LINK 2'h2
`define PSP_LED_DUPLEX 2'h3

`endif

// [rtl/psp_sync2.v]
// Two-flop synchroniser for a group of independent pin levels.
// Assumes slow levels; no coherence between bits.
`timescale 1ns/1ps
module psp_sync2 #(
  parameter W = 1
) (
  input wire clk,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg; // First stage, read only by the second

  // No reset: it must sample while reset holds the straps open
  always @(posedge clk) begin
    meta_reg <= d;
    q <= meta_reg;
  end
endmodule // psp_sync2

// [rtl/psp_led_sel.v]
// One indicator output with a selectable source.
// Assumes all sources are on the same clock.
`timescale 1ns/1ps
`include "psp_regs.vh"
module psp_led_sel (
  input wire clk,
  input wire rst,
  input wire [1:0] sel,
  input wire activity,
  input wire speed100,
  input wire link,
  input wire duplex,
  output reg led
);
  reg led_next; // Selected source

  // Pick the selected source
  always @* begin
    case (sel)
      `PSP_LED_ACT: led_next = activity;
      `PSP_LED_SPEED: led_next = speed100;
      `PSP_LED_LINK: led_next = link;
      default: led_next = duplex;
    endcase
  end

  // Registered so the pin never glitches between sources
  always @(posedge clk) begin
    if (rst) begin
      led <= 1'b0;
    end else begin
      led <= led_next;
    end
  end
endmodule // psp_led_sel

// [rtl/psp_strap_pins.v]
// Strap latch and shared-pin mux of a PHY, with AXI4-Lite registers.
// Assumes clk is the 50 MHz reference and rst the chip reset, active high.
`timescale 1ns/1ps
`include "psp_regs.vh"
module psp_strap_pins #(
  parameter NEVT = 8
) (
  input wire clk,
  input wire rst,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Shared pins: input, output, output enable
  input wire addr_bit0_indicator0_i,
  output wire addr_bit0_indicator0_o,
  output wire addr_bit0_indicator0_oe,
  input wire addr_bit1_isolate_indicator1_i,
  output wire addr_bit1_isolate_indicator1_o,
  output wire addr_bit1_isolate_indicator1_oe,
  input wire addr2_strap_irq_out_i,
  output reg addr2_strap_irq_out_o,
  output wire addr2_strap_irq_out_oe,
  input wire addr_bit4_indicator2_i,
  output wire addr_bit4_indicator2_o,
  output wire addr_bit4_indicator2_oe,
  input wire rx_isolate_strap_rxbit1_i,
  output wire rx_isolate_strap_rxbit1_o,
  output wire rx_isolate_strap_rxbit1_oe,
  input wire duplex_strap_rxbit0_i,
  output wire duplex_strap_rxbit0_o,
  output wire duplex_strap_rxbit0_oe,
  input wire iface_mode_strap_crs_valid_i,
  output wire iface_mode_strap_crs_valid_o,
  output wire iface_mode_strap_crs_valid_oe,
  input wire role_strap_rx_error_i,
  output wire role_strap_rx_error_o,
  output wire role_strap_rx_error_oe,
  // Input-only strap pins and the live rate pin
  input wire addr_bit3_strap,
  input wire speed_ctrl_source_strap,
  input wire full_reg_access_strap,
  input wire auto_crossover_strap,
  input wire autoneg_strap,
  input wire speed_strap,
  input wire live_rate_select,
  // MAC transmit pins
  input wire tx_enable_pin,
  input wire [1:0] tx_data_pin,
  input wire transmit_error_in,
  // Indicator pins without a strap role
  output wire indicator3_out,
  output wire indicator4_out,
  // Core side: receive stream in, transmit stream out
  input wire rx_valid_in,
  input wire [1:0] rx_bits_in,
  input wire rx_error_in,
  output reg tx_valid_out,
  output reg [1:0] tx_bits_out,
  output reg tx_error_out,
  // Core side: link state and event pulses
  input wire link_up_in,
  input wire an_speed100_in,
  input wire an_full_duplex_in,
  input wire [NEVT-1:0] event_in,
  // Core side: configuration that results from the straps
  output wire [4:0] phy_addr_out,
  output wire autoneg_en_out,
  output wire speed100_out,
  output wire full_duplex_out,
  output wire crossover_en_out,
  output wire full_reg_access_out,
  output wire repeater_mode_out,
  output wire rmii_mode_out,
  output wire rx_isolate_out
);
  localparam [1:0] RESP_OKAY = 2'h0; // AXI response codes
  localparam [1:0] RESP_SLVERR = 2'h2;

  // Synchronised pin levels
  wire [15:0] pin_sync; // Strap and live inputs after two flops
  wire [3:0] tx_sync; // Transmit pins after two flops

  psp_sync2 #(.W(16)) u_pin_sync (
    .clk(clk),
    .d({addr_bit0_indicator0_i, addr_bit1_isolate_indicator1_i, addr2_strap_irq_out_i,
        addr_bit3_strap, addr_bit4_indicator2_i, autoneg_strap, duplex_strap_rxbit0_i,
        speed_strap, speed_ctrl_source_strap, full_reg_access_strap, auto_crossover_strap,
        rx_isolate_strap_rxbit1_i, iface_mode_strap_crs_valid_i, role_strap_rx_error_i,
        live_rate_select, 1'b0}),
    .q(pin_sync)
  );

  psp_sync2 #(.W(4)) u_tx_sync (
    .clk(clk),
    .d({tx_enable_pin, tx_data_pin, transmit_error_in}),
    .q(tx_sync)
  );

  // Named synchronised levels
  wire [4:0] s_addr = {pin_sync[11], pin_sync[12], pin_sync[13], pin_sync[14], pin_sync[15]};
  wire s_an = pin_sync[10];
  wire s_dup = pin_sync[9];
  wire s_spd = pin_sync[8];
  wire s_src = pin_sync[7];
  wire s_reg = pin_sync[6];
  wire s_xov = pin_sync[5];
  wire s_iso = pin_sync[4];
  wire s_rmii = pin_sync[3];
  wire s_role = pin_sync[2];
  wire s_live = pin_sync[1];
  wire s_iso_ctl = pin_sync[14]; // Address-one pin as isolate control

  // Strap storage
  reg [13:0] strap_reg; // Layout follows the straps register
  reg run_reg; // High once reset has ended

  // Straps sampled each reset cycle; the last one is kept
  always @(posedge clk) begin
    if (rst) begin
      strap_reg[4:0] <= {1'b1, s_addr[3:0]};
      strap_reg[`PSP_ST_AN] <= s_an;
      strap_reg[`PSP_ST_DUPLEX] <= s_dup;
      strap_reg[`PSP_ST_SPEED] <= s_spd;
      strap_reg[`PSP_ST_SPD_SRC] <= s_src;
      strap_reg[`PSP_ST_REGACC] <= s_reg;
      strap_reg[`PSP_ST_XOVER] <= s_xov;
      strap_reg[`PSP_ST_ISO] <= s_iso;
      strap_reg[`PSP_ST_RMII] <= s_rmii;
      strap_reg[`PSP_ST_ROLE] <= s_role;
      run_reg <= 1'b0;
    end else begin
      run_reg <= 1'b1;
    end
  end

  // Software registers
  reg [3:0] ctrl_reg; // Polarity, speed, duplex, speed source
  reg [NEVT-1:0] irq_en_reg; // Event enables
  reg [NEVT-1:0] irq_stat_reg; // Sticky event flags
  reg [9:0] led_sel_reg; // Two select bits per indicator

  // AXI write channel state
  reg aw_full_reg; // Address held
  reg w_full_reg; // Data held
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_full_reg && !s_axi_bvalid;

  wire wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid; // Both halves present
  wire wr_ctrl = wr_fire && (aw_addr_reg[7:2] == `PSP_OFF_CTRL >> 2);
  wire wr_en = wr_fire && (aw_addr_reg[7:2] == `PSP_OFF_IRQ_EN >> 2);
  wire wr_stat = wr_fire && (aw_addr_reg[7:2] == `PSP_OFF_IRQ_STAT >> 2);
  wire wr_led = wr_fire && (aw_addr_reg[7:2] == `PSP_OFF_LED_SEL >> 2);
  wire wr_ro = wr_fire && ((aw_addr_reg[7:2] == `PSP_OFF_STRAPS >> 2) ||
                           (aw_addr_reg[7:2] == `PSP_OFF_LIVE >> 2));
  wire wr_hit = wr_ctrl || wr_en || wr_stat || wr_led || wr_ro;

  // Byte-lane mask for partial writes
  wire [31:0] lane_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                           {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  // Capture address and data in any order; answer once both are in
  always @(posedge clk) begin
    if (rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR; // Unmapped gets an error
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control speed, duplex and source bits reset to the straps, so software sees the strapped mode
  always @(posedge clk) begin
    if (rst) begin
      ctrl_reg[`PSP_CTRL_IRQ_POL] <= `PSP_IRQ_POL_RST;
      ctrl_reg[`PSP_CTRL_SPEED] <= s_spd;
      ctrl_reg[`PSP_CTRL_DUPLEX] <= s_dup;
      ctrl_reg[`PSP_CTRL_SPD_SRC] <= s_src;
      irq_en_reg <= `PSP_IRQ_EN_RST;
      led_sel_reg <= `PSP_LED_SEL_RST;
    end else begin
      if (wr_ctrl && w_strb_reg[0]) begin
        ctrl_reg <= w_data_reg[3:0];
      end
      if (wr_en) begin
        irq_en_reg <= (irq_en_reg & ~lane_mask[NEVT-1:0]) |
                      (w_data_reg[NEVT-1:0] & lane_mask[NEVT-1:0]);
      end
      if (wr_led) begin
        led_sel_reg <= (led_sel_reg & ~lane_mask[9:0]) | (w_data_reg[9:0] & lane_mask[9:0]);
      end
    end
  end

  // Sticky flags; an event in the clearing cycle beats the clear
  wire [NEVT-1:0] stat_clr = wr_stat ? (w_data_reg[NEVT-1:0] & lane_mask[NEVT-1:0])
                                     : {NEVT{1'b0}};
  always @(posedge clk) begin
    if (rst) begin
      irq_stat_reg <= {NEVT{1'b0}};
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~stat_clr) | (event_in & irq_en_reg);
    end
  end

  // Effective link mode
  wire an_on = strap_reg[`PSP_ST_AN];
  wire spd_forced = ctrl_reg[`PSP_CTRL_SPD_SRC] ? s_live : ctrl_reg[`PSP_CTRL_SPEED];
  wire speed_eff = an_on ? an_speed100_in : spd_forced;
  wire duplex_eff = an_on ? an_full_duplex_in : ctrl_reg[`PSP_CTRL_DUPLEX];
  wire irq_level = |irq_stat_reg;
  wire iso_mode = strap_reg[`PSP_ST_ISO];
  wire rx_hidden = iso_mode && s_iso_ctl; // Only after an iso strap

  // Read answered the cycle after the address is taken
  reg [31:0] rd_data;
  reg rd_hit;
  always @* begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr[7:2])
      `PSP_OFF_CTRL >> 2: rd_data[3:0] = ctrl_reg;
      `PSP_OFF_IRQ_EN >> 2: rd_data[NEVT-1:0] = irq_en_reg;
      `PSP_OFF_IRQ_STAT >> 2: rd_data[NEVT-1:0] = irq_stat_reg;
      `PSP_OFF_LED_SEL >> 2: rd_data[9:0] = led_sel_reg;
      `PSP_OFF_STRAPS >> 2: rd_data[13:0] = strap_reg;
      `PSP_OFF_LIVE >> 2: rd_data[2:0] = {irq_level, duplex_eff, speed_eff};
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Hold the read answer until the master takes it
  always @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Interrupt pin level per polarity bit
  always @(posedge clk) begin
    if (rst) begin
      addr2_strap_irq_out_o <= 1'b1;
    end else begin
      addr2_strap_irq_out_o <= ctrl_reg[`PSP_CTRL_IRQ_POL] ? irq_level : !irq_level;
    end
  end

  // Receive path to the MAC; data low outside valid
  reg rx_dv_reg;
  reg [1:0] rxd_reg;
  reg rx_er_reg;
  always @(posedge clk) begin
    if (rst) begin
      rx_dv_reg <= 1'b0;
      rxd_reg <= 2'h0;
      rx_er_reg <= 1'b0;
    end else begin
      rx_dv_reg <= rx_valid_in;
      rxd_reg <= rx_valid_in ? rx_bits_in : 2'h0;
      rx_er_reg <= rx_valid_in && rx_error_in;
    end
  end

  // Transmit path from the MAC
  always @(posedge clk) begin
    if (rst) begin
      tx_valid_out <= 1'b0;
      tx_bits_out <= 2'h0;
      tx_error_out <= 1'b0;
    end else begin
      tx_valid_out <= tx_sync[3];
      tx_bits_out <= tx_sync[3] ? tx_sync[2:1] : 2'h0;
      tx_error_out <= tx_sync[3] && tx_sync[0];
    end
  end

  // Indicators, one selector each
  wire [4:0] led_q;
  wire activity = rx_dv_reg || tx_valid_out;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_led
      psp_led_sel u_led (
        .clk(clk),
        .rst(rst),
        .sel(led_sel_reg[2*gi+1:2*gi]),
        .activity(activity),
        .speed100(speed_eff),
        .link(link_up_in),
        .duplex(duplex_eff),
        .led(led_q[gi])
      );
    end
  endgenerate

  // Shared pins drive only after reset; rx pins obey isolation
  assign addr_bit0_indicator0_o = led_q[0];
  assign addr_bit0_indicator0_oe = run_reg;
  assign addr_bit1_isolate_indicator1_o = led_q[1];
  assign addr_bit1_isolate_indicator1_oe = run_reg && !iso_mode;
  assign addr2_strap_irq_out_oe = run_reg;
  assign addr_bit4_indicator2_o = led_q[2];
  assign addr_bit4_indicator2_oe = run_reg;
  assign rx_isolate_strap_rxbit1_o = rxd_reg[1];
  assign rx_isolate_strap_rxbit1_oe = run_reg && !rx_hidden;
  assign duplex_strap_rxbit0_o = rxd_reg[0];
  assign duplex_strap_rxbit0_oe = run_reg && !rx_hidden;
  assign iface_mode_strap_crs_valid_o = rx_dv_reg;
  assign iface_mode_strap_crs_valid_oe = run_reg && !rx_hidden;
  assign role_strap_rx_error_o = rx_er_reg;
  assign role_strap_rx_error_oe = run_reg && !rx_hidden;
  assign indicator3_out = led_q[3];
  assign indicator4_out = led_q[4];

  // Configuration toward the core
  assign phy_addr_out = strap_reg[4:0];
  assign autoneg_en_out = an_on;
  assign speed100_out = speed_eff;
  assign full_duplex_out = duplex_eff;
  assign crossover_en_out = strap_reg[`PSP_ST_XOVER];
  assign full_reg_access_out = strap_reg[`PSP_ST_REGACC];
  assign repeater_mode_out = strap_reg[`PSP_ST_ROLE];
  assign rmii_mode_out = strap_reg[`PSP_ST_RMII];
  assign rx_isolate_out = rx_hidden;
endmodule // psp_strap_pins

// [tb/psp_strap_pins_asserts.sv]
// Port checks for the strap latch and shared-pin block.
// Assumes clk and the synchronous active-high reset rst.
`timescale 1ns/1ps
module psp_strap_pins_chk (
  input wire clk,
  input wire rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire addr_bit0_indicator0_oe,
  input wire addr2_strap_irq_out_o,
  input wire rx_isolate_strap_rxbit1_o,
  input wire duplex_strap_rxbit0_o,
  input wire iface_mode_strap_crs_valid_o,
  input wire role_strap_rx_error_o,
  input wire tx_enable_pin,
  input wire rx_valid_in,
  input wire [1:0] rx_bits_in,
  input wire rx_error_in,
  input wire tx_valid_out,
  input wire an_speed100_in,
  input wire an_full_duplex_in,
  input wire [4:0] phy_addr_out,
  input wire autoneg_en_out,
  input wire speed100_out,
  input wire full_duplex_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Both write halves taken
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Response not yet taken
  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  wr_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("bresp late");
  b_hold_a: assert property (b_wait |=> s_axi_bvalid)
    else $error("bvalid dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("rvalid late");
  // Watched in reset too
  oe_off_reset_a: assert property (disable iff (1'b0) rst |=> !addr_bit0_indicator0_oe)
    else $error("pin driven in reset");
  irq_idle_reset_a: assert property (disable iff (1'b0) rst |=> addr2_strap_irq_out_o)
    else $error("irq active in reset");
  oe_on_release_a: assert property ($fell(rst) |=> addr_bit0_indicator0_oe)
    else $error("pin idle after reset");
  addr4_high_a: assert property (phy_addr_out[4])
    else $error("addr bit 4 low");
  rx_pass_a: assert property (rx_valid_in |=> iface_mode_strap_crs_valid_o &&
    {rx_isolate_strap_rxbit1_o, duplex_strap_rxbit0_o} == $past(rx_bits_in))
    else $error("rx pair lost");
  rx_idle_a: assert property (!rx_valid_in |=> !iface_mode_strap_crs_valid_o)
    else $error("stray crs valid");
  rx_err_a: assert property (rx_valid_in && rx_error_in |=> role_strap_rx_error_o)
    else $error("rx error lost");
  tx_delay_a: assert property (!$past(rst) |-> tx_valid_out == $past(tx_enable_pin, 3))
    else $error("tx valid timing");
  an_follow_a: assert property (autoneg_en_out |-> speed100_out == an_speed100_in &&
    full_duplex_out == an_full_duplex_in)
    else $error("AN mode ignored");
endmodule // psp_strap_pins_chk

bind psp_strap_pins psp_strap_pins_chk chk_u (.*);

// [tb/psp_mac_model.sv]
// Behavioural MAC on the reduced interface: sends and collects dibits.
// Assumes the reference clock is shared with the PHY side.
`timescale 1ns/1ps
module psp_mac_model (
  input wire clk,
  input wire crs_dv,
  input wire [1:0] rxd,
  output reg tx_en = 1'b0,
  output reg [1:0] txd = 2'h0,
  output reg tx_er = 1'b0,
  output reg [7:0] rx_byte = 8'h00,
  output reg [3:0] rx_cnt = 4'h0
);
  // Two bits per valid cycle, first pair lowest
  always @(posedge clk) begin
    if (crs_dv) begin
      rx_byte <= {rxd, rx_byte[7:2]};
      rx_cnt <= rx_cnt + 4'h1;
    end
  end
  // One byte as four pairs, low pair first
  task send_byte(input [7:0] b);
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge clk);
        tx_en <= 1'b1;
        txd <= b[2*i +: 2];
      end
      @(posedge clk);
      tx_en <= 1'b0;
      // Junk when idle so a stale pair cannot pass
      txd <= ~b[7:6];
    end
  endtask
endmodule // psp_mac_model

// [tb/test_phy_strap_pin_config.sv]
// Bench: straps over two resets, registers, streams and events.
// Assumes psp_regs.vh is on the include path.
`timescale 1ns/1ps
`include "psp_regs.vh"
module test_phy_strap_pin_config;
  reg clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [7:0] s_axi_awaddr, s_axi_araddr, event_in, ext, txcap;
  reg [31:0] s_axi_wdata, rdat;
  reg [3:0] s_axi_wstrb;
  reg [1:0] rsp, rx_bits_in;
  reg addr_bit3_strap, speed_ctrl_source_strap, full_reg_access_strap, auto_crossover_strap;
  reg autoneg_strap, speed_strap, live_rate_select, rx_valid_in, rx_error_in;
  reg link_up_in, an_speed100_in, an_full_duplex_in;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, tx_data_pin, tx_bits_out;
  wire [31:0] s_axi_rdata;
  wire addr_bit0_indicator0_i, addr_bit0_indicator0_o, addr_bit0_indicator0_oe;
  wire addr_bit1_isolate_indicator1_i, addr_bit1_isolate_indicator1_o;
  wire addr_bit1_isolate_indicator1_oe;
  wire addr2_strap_irq_out_i, addr2_strap_irq_out_o, addr2_strap_irq_out_oe;
  wire addr_bit4_indicator2_i, addr_bit4_indicator2_o, addr_bit4_indicator2_oe;
  wire rx_isolate_strap_rxbit1_i, rx_isolate_strap_rxbit1_o, rx_isolate_strap_rxbit1_oe;
  wire duplex_strap_rxbit0_i, duplex_strap_rxbit0_o, duplex_strap_rxbit0_oe;
  wire iface_mode_strap_crs_valid_i, iface_mode_strap_crs_valid_o;
  wire iface_mode_strap_crs_valid_oe;
  wire role_strap_rx_error_i, role_strap_rx_error_o, role_strap_rx_error_oe;
  wire tx_enable_pin, transmit_error_in, indicator3_out, indicator4_out, tx_valid_out;
  wire tx_error_out, autoneg_en_out, speed100_out, full_duplex_out, crossover_en_out;
  wire full_reg_access_out, repeater_mode_out, rmii_mode_out, rx_isolate_out;
  wire [4:0] phy_addr_out;
  wire [7:0] po, poe;
  integer fail_count, checked, i, n;
  integer txn = 0;
  // Order: role crs rx0 rx1 a4 irq a1 a0
  assign po = {role_strap_rx_error_o, iface_mode_strap_crs_valid_o, duplex_strap_rxbit0_o,
    rx_isolate_strap_rxbit1_o, addr_bit4_indicator2_o, addr2_strap_irq_out_o,
    addr_bit1_isolate_indicator1_o, addr_bit0_indicator0_o};
  assign poe = {role_strap_rx_error_oe, iface_mode_strap_crs_valid_oe, duplex_strap_rxbit0_oe,
    rx_isolate_strap_rxbit1_oe, addr_bit4_indicator2_oe, addr2_strap_irq_out_oe,
    addr_bit1_isolate_indicator1_oe, addr_bit0_indicator0_oe};
  // Driver wins, else the strap level
  assign {role_strap_rx_error_i, iface_mode_strap_crs_valid_i, duplex_strap_rxbit0_i,
    rx_isolate_strap_rxbit1_i, addr_bit4_indicator2_i, addr2_strap_irq_out_i,
    addr_bit1_isolate_indicator1_i, addr_bit0_indicator0_i} = (poe & po) | (~poe & ext);
  psp_strap_pins dut_u (.*);
  psp_mac_model mac_u (.clk(clk), .crs_dv(iface_mode_strap_crs_valid_i),
    .rxd({rx_isolate_strap_rxbit1_i, duplex_strap_rxbit0_i}), .tx_en(tx_enable_pin),
    .txd(tx_data_pin), .tx_er(transmit_error_in), .rx_byte(), .rx_cnt());
  // 50 MHz reference
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Collect transmit pairs
  always @(posedge clk) begin
    if (tx_valid_out) begin
      txcap <= {tx_bits_out, txcap[7:2]};
      txn <= txn + 1;
    end
  end
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task hang;
    begin
      chk("wait", 0, 1);
      close_out;
    end
  endtask
  // Write: aw and w together, each released when taken
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      if (!s_axi_bvalid) hang;
      s_axi_bready <= 1'b0;
      rsp = s_axi_bresp;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      if (!s_axi_rvalid) hang;
      s_axi_rready <= 1'b0;
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
    end
  endtask
  // Strap vector in straps register layout
  task reset_chk(input [13:0] s);
    begin
      @(posedge clk);
      rst <= 1'b1;
      ext <= {s[13], s[12], s[6], s[11], s[4], s[2:0]};
      {addr_bit3_strap, autoneg_strap, speed_strap} <= {s[3], s[5], s[7]};
      {speed_ctrl_source_strap, full_reg_access_strap, auto_crossover_strap} <= {s[8], s[9], s[10]};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(`PSP_OFF_STRAPS);
      chk("straps", rdat, {18'h0, s | 14'h0010});
      chk("cfg", {repeater_mode_out, rmii_mode_out, crossover_en_out, full_reg_access_out,
        autoneg_en_out, phy_addr_out}, {s[13], s[12], s[10], s[9], s[5], 1'b1, s[3:0]});
      rd(`PSP_OFF_CTRL);
      chk("ctrl", rdat, {28'h0, s[8], s[6], s[7], 1'b0});
    end
  endtask
  task pulse(input [7:0] e);
    begin
      @(posedge clk);
      event_in <= e;
      @(posedge clk);
      event_in <= 8'h00;
      repeat (2) @(posedge clk);
    end
  endtask
  initial begin
    fail_count = 0;
    checked = 0;
    rst = 1'b1;
    {ext, event_in, txcap, s_axi_awaddr, s_axi_araddr} = 40'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_wdata, s_axi_wstrb} = {32'h0, 4'hF};
    {addr_bit3_strap, speed_ctrl_source_strap, full_reg_access_strap} = 3'h0;
    {auto_crossover_strap, autoneg_strap, speed_strap, live_rate_select} = 4'h0;
    {rx_valid_in, rx_bits_in, rx_error_in, link_up_in} = 5'h01;
    {an_speed100_in, an_full_duplex_in} = 2'h0;
    reset_chk(14'h334D);
    rd(`PSP_OFF_LED_SEL);
    chk("led_sel", rdat, 32'h3A4);
    rd(8'h20);
    chk("unmapped", {rsp, rdat[29:0]}, {2'h2, 30'h0});
    wr(`PSP_OFF_STRAPS, 32'h0);
    rd(`PSP_OFF_STRAPS);
    chk("ro_straps", rdat, 32'h335D);
    $display("test registers done");
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk);
      live_rate_select <= i[0];
      repeat (4) @(posedge clk);
      chk("live_speed", speed100_out, i);
      chk("led1_speed", addr_bit1_isolate_indicator1_o, i);
      chk("duplex_strap", full_duplex_out, 1);
    end
    wr(`PSP_OFF_CTRL, 32'h0);
    chk("reg_speed", {speed100_out, full_duplex_out}, 0);
    $display("test speed done");
    mac_u.send_byte(8'hB4);
    for (n = 0; txn < 4 && n < 20; n = n + 1) @(posedge clk);
    chk("tx_byte", {tx_error_out, txcap}, 9'h0B4);
    n = mac_u.rx_cnt;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk);
      if (i == 3) chk("led_act", addr_bit0_indicator0_o, 1);
      rx_valid_in <= 1'b1;
      rx_bits_in <= 8'hC6 >> (2 * i);
      rx_error_in <= (i == 2);
    end
    @(posedge clk);
    {rx_valid_in, rx_error_in} <= 2'h0;
    repeat (2) @(posedge clk);
    chk("rx_byte", {mac_u.rx_cnt - n[3:0], mac_u.rx_byte}, 12'h4C6);
    $display("test streams done");
    wr(`PSP_OFF_IRQ_EN, 32'hFF);
    for (i = 0; i < 8; i = i + 1) begin
      pulse(8'h01 << i);
      rd(`PSP_OFF_IRQ_STAT);
      chk("irq_stat", {addr2_strap_irq_out_o, rdat[30:0]}, {1'b0, 31'h1 << i});
      wr(`PSP_OFF_IRQ_STAT, 32'h1 << i);
      rd(`PSP_OFF_IRQ_STAT);
      chk("irq_clear", {addr2_strap_irq_out_o, rdat[30:0]}, {1'b1, 31'h0});
    end
    wr(`PSP_OFF_CTRL, 32'h1);
    pulse(8'h20);
    rd(`PSP_OFF_IRQ_STAT);
    chk("irq_high", addr2_strap_irq_out_o, 1);
    wr(`PSP_OFF_IRQ_EN, 32'h0);
    wr(`PSP_OFF_IRQ_STAT, 32'hFF);
    pulse(8'h40);
    rd(`PSP_OFF_IRQ_STAT);
    chk("irq_mask", {addr2_strap_irq_out_o, rdat[30:0]}, 32'h0);
    $display("test events done");
    reset_chk(14'h1CB2);
    chk("iso", {rx_isolate_out, rx_isolate_strap_rxbit1_oe}, 2'h2);
    @(posedge clk);
    ext[1] <= 1'b0;
    an_speed100_in <= 1'b1;
    repeat (4) @(posedge clk);
    chk("iso_off", {rx_isolate_out, speed100_out}, 2'h1);
    $display("test second reset done");
    close_out;
  end
endmodule // test_phy_strap_pin_config
